// [tcoc_pkg.sv]
package tcoc_pkg;

    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;

    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_CMP_A = 4'h4;
    localparam logic [3:0] WGM_CTC_CAPTURE = 4'hc;

    localparam logic [1:0] COM_NONE = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [15:0] RST_COMPARE = 16'h0000;
    localparam logic [15:0] RST_CAPTURE = 16'h0000;
    localparam logic RST_OUTPUT_BIT = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [1:0] RST_COM = 2'h0;

    localparam int NUM_CHAN = 2;

    typedef enum logic [1:0] {
        CNT_NORMAL,
        CNT_CTC_A,
        CNT_CTC_CAP,
        CNT_PWM
    } tcoc_count_t;

endpackage : tcoc_pkg

// [tcoc_cmp_if.sv]
`timescale 1ns/100ps

interface tcoc_cmp_if;
    logic tick;
    logic [15:0] counter;
    logic [15:0] compare_value;
    logic blocked;
    logic [1:0] output_mode;
    logic force_strobe;
    logic non_pwm;
    logic flag_clr;
    logic port_data;
    logic port_dir;
    logic match;
    logic flag;
    logic oc_bit;
    logic pin_out;
    logic pin_oe;

    modport channel (
        input tick, counter, compare_value, blocked, output_mode, force_strobe,
        input non_pwm, flag_clr, port_data, port_dir,
        output match, flag, oc_bit, pin_out, pin_oe
    );

    modport timer (
        output tick, counter, compare_value, blocked, output_mode, force_strobe,
        output non_pwm, flag_clr, port_data, port_dir,
        input match, flag, oc_bit, pin_out, pin_oe
    );
endinterface : tcoc_cmp_if

// [tcoc_channel.sv]
`timescale 1ns/100ps

module tcoc_channel (
    input wire logic clk,
    input wire logic rst,
    tcoc_cmp_if.channel ch
);

    logic [1:0] com_reg;
    logic oc_reg;
    logic oc_next;
    logic flag_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic act;

    // Written counter blocks the match on the following timer tick
    assign ch.match = ch.tick & ~ch.blocked & (ch.counter == ch.compare_value);

    // Forced compare acts only in non-PWM modes and never sets the flag
    assign act = ch.match | (ch.force_strobe & ch.non_pwm);

    // Action uses the mode held before this cycle, so a new mode waits for a later match
    always_comb begin
        oc_next = oc_reg;
        if (act) begin
            case (com_reg)
                tcoc_pkg::COM_NONE: oc_next = oc_reg;
                tcoc_pkg::COM_TOGGLE: oc_next = ~oc_reg;
                tcoc_pkg::COM_CLEAR: oc_next = 1'b0;
                tcoc_pkg::COM_SET: oc_next = 1'b1;
                default: oc_next = oc_reg;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            com_reg <= tcoc_pkg::RST_COM;
        end else begin
            com_reg <= ch.output_mode;
        end
    end

    // Output bit settable by a forced compare before the pin is enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_reg <= tcoc_pkg::RST_OUTPUT_BIT;
        end else begin
            oc_reg <= oc_next;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_reg <= tcoc_pkg::RST_FLAG;
        end else if (ch.match) begin
            flag_reg <= 1'b1;
        end else if (ch.flag_clr) begin
            flag_reg <= 1'b0;
        end
    end

    // Pin follows override and output bit in the cycle the mode register updates
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_oe_reg <= ch.port_dir;
            if (!ch.port_dir) begin
                pin_out_reg <= 1'b0;
            end else if (ch.output_mode != tcoc_pkg::COM_NONE) begin
                pin_out_reg <= oc_next;
            end else begin
                pin_out_reg <= ch.port_data;
            end
        end
    end

    assign ch.flag = flag_reg;
    assign ch.oc_bit = oc_reg;
    assign ch.pin_out = pin_out_reg;
    assign ch.pin_oe = pin_oe_reg;

endmodule : tcoc_channel

// [tcoc_timer.sv]
`timescale 1ns/100ps

// Function
// - Reset clears compare output bit
// - Nonzero output mode overrides port data
// - Port direction bit still controls pin
// - Software can preset output bit before enable
// - Output mode never affects capture unit
// - Output mode zero leaves bit unchanged
// - New output mode applies at next match
// - Force strobe acts immediately in non-PWM
// - Counting depends only on waveform mode
// - Output mode selects set, clear, toggle
// - Mode zero counts up, wraps at max
// - Overflow set when counter wraps from max to zero
// - Overflow interrupt execution clears flag
// - Normal mode accepts counter writes anytime
// - Modes 4/12 clear on A/capture match
// - Top match sets A or capture flag
// - Top unbuffered; lower top wraps first
// - Toggle mode toggles A on match
// - Toggle frequency clock over 2N(1+A)
// - Overflow set on max to zero
// - Force sets no flag, keeps counter
// - Match sets flag next timer cycle
// - Counter write blocks next cycle's match
module tcoc_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic timer_tick,
    input wire logic [3:0] waveform_mode,
    input wire logic [1:0] compare_a_output_mode,
    input wire logic [1:0] compare_b_output_mode,
    input wire logic counter_write,
    input wire logic [15:0] counter_write_value,
    input wire logic compare_a_write,
    input wire logic [15:0] compare_a_write_value,
    input wire logic compare_b_write,
    input wire logic [15:0] compare_b_write_value,
    input wire logic capture_write,
    input wire logic [15:0] capture_write_value,
    input wire logic capture_event,
    input wire logic force_compare_a_strobe,
    input wire logic force_compare_b_strobe,
    input wire logic overflow_clear,
    input wire logic overflow_int_ack,
    input wire logic compare_a_clear,
    input wire logic compare_a_int_ack,
    input wire logic compare_b_clear,
    input wire logic compare_b_int_ack,
    input wire logic capture_clear,
    input wire logic capture_int_ack,
    input wire logic port_a_data,
    input wire logic port_a_dir,
    input wire logic port_b_data,
    input wire logic port_b_dir,
    output logic [15:0] counter_value,
    output logic [15:0] compare_a_value,
    output logic [15:0] compare_b_value,
    output logic [15:0] capture_value,
    output logic overflow_flag,
    output logic compare_a_flag,
    output logic compare_b_flag,
    output logic capture_flag,
    output logic compare_a_output_bit,
    output logic compare_b_output_bit,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);

    function automatic tcoc_pkg::tcoc_count_t count_mode(input logic [3:0] wgm);
        case (wgm)
            tcoc_pkg::WGM_NORMAL: count_mode = tcoc_pkg::CNT_NORMAL;
            tcoc_pkg::WGM_CTC_CMP_A: count_mode = tcoc_pkg::CNT_CTC_A;
            tcoc_pkg::WGM_CTC_CAPTURE: count_mode = tcoc_pkg::CNT_CTC_CAP;
            default: count_mode = tcoc_pkg::CNT_PWM;
        endcase
    endfunction : count_mode

    logic [15:0] counter_reg;
    logic [15:0] counter_next;
    logic [15:0] compare_a_reg;
    logic [15:0] compare_b_reg;
    logic [15:0] capture_reg;
    logic overflow_reg;
    logic capture_flag_reg;
    logic block_reg;
    tcoc_pkg::tcoc_count_t mode;
    logic cap_top_match;
    logic top_match;
    logic wrap_now;
    logic capture_take;

    logic [15:0] cmp_val [tcoc_pkg::NUM_CHAN];
    logic [1:0] com_in [tcoc_pkg::NUM_CHAN];
    logic force_in [tcoc_pkg::NUM_CHAN];
    logic clr_in [tcoc_pkg::NUM_CHAN];
    logic pdata_in [tcoc_pkg::NUM_CHAN];
    logic pdir_in [tcoc_pkg::NUM_CHAN];

    tcoc_cmp_if chan_if [tcoc_pkg::NUM_CHAN] ();

    assign mode = count_mode(waveform_mode);

    assign cmp_val[0] = compare_a_reg;
    assign cmp_val[1] = compare_b_reg;
    assign com_in[0] = compare_a_output_mode;
    assign com_in[1] = compare_b_output_mode;
    assign force_in[0] = force_compare_a_strobe;
    assign force_in[1] = force_compare_b_strobe;
    assign clr_in[0] = compare_a_clear | compare_a_int_ack;
    assign clr_in[1] = compare_b_clear | compare_b_int_ack;
    assign pdata_in[0] = port_a_data;
    assign pdata_in[1] = port_b_data;
    assign pdir_in[0] = port_a_dir;
    assign pdir_in[1] = port_b_dir;

    genvar gi;
    generate
        for (gi = 0; gi < tcoc_pkg::NUM_CHAN; gi++) begin : g_chan
            assign chan_if[gi].tick = timer_tick;
            assign chan_if[gi].counter = counter_reg;
            assign chan_if[gi].compare_value = cmp_val[gi];
            assign chan_if[gi].blocked = block_reg;
            assign chan_if[gi].output_mode = com_in[gi];
            assign chan_if[gi].force_strobe = force_in[gi];
            assign chan_if[gi].non_pwm = (mode != tcoc_pkg::CNT_PWM);
            assign chan_if[gi].flag_clr = clr_in[gi];
            assign chan_if[gi].port_data = pdata_in[gi];
            assign chan_if[gi].port_dir = pdir_in[gi];

            tcoc_channel u_chan (
                .clk(clk),
                .rst(rst),
                .ch(chan_if[gi])
            );
        end
    endgenerate

    // Top comparisons are against live registers, no buffering
    assign cap_top_match = timer_tick & ~block_reg & (counter_reg == capture_reg);

    always_comb begin
        case (mode)
            tcoc_pkg::CNT_CTC_A: top_match = chan_if[0].match;
            tcoc_pkg::CNT_CTC_CAP: top_match = cap_top_match;
            tcoc_pkg::CNT_NORMAL: top_match = 1'b0;
            default: top_match = 1'b0;
        endcase
    end

    assign wrap_now = timer_tick & ~counter_write & (counter_reg == tcoc_pkg::CNT_MAX);

    always_comb begin
        counter_next = counter_reg;
        if (counter_write) begin
            counter_next = counter_write_value;
        end else if (timer_tick) begin
            if (top_match) begin
                counter_next = tcoc_pkg::CNT_BOTTOM;
            end else begin
                counter_next = counter_reg + tcoc_pkg::CNT_STEP;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_reg <= tcoc_pkg::RST_COUNTER;
        end else begin
            counter_reg <= counter_next;
        end
    end

    // Held until a timer tick consumes it, so it also works while stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            block_reg <= 1'b0;
        end else if (counter_write) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_a_reg <= tcoc_pkg::RST_COMPARE;
        end else if (compare_a_write) begin
            compare_a_reg <= compare_a_write_value;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_b_reg <= tcoc_pkg::RST_COMPARE;
        end else if (compare_b_write) begin
            compare_b_reg <= compare_b_write_value;
        end
    end

    // Capture input is idle while the capture register defines top
    assign capture_take = capture_event & (mode != tcoc_pkg::CNT_CTC_CAP);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_reg <= tcoc_pkg::RST_CAPTURE;
        end else if (capture_write) begin
            capture_reg <= capture_write_value;
        end else if (capture_take) begin
            capture_reg <= counter_reg;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_flag_reg <= tcoc_pkg::RST_FLAG;
        end else if (capture_take) begin
            capture_flag_reg <= 1'b1;
        end else if ((mode == tcoc_pkg::CNT_CTC_CAP) && cap_top_match) begin
            capture_flag_reg <= 1'b1;
        end else if (capture_clear || capture_int_ack) begin
            capture_flag_reg <= 1'b0;
        end
    end

    // Set wins over clear; counting itself never clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_reg <= tcoc_pkg::RST_FLAG;
        end else if (wrap_now) begin
            overflow_reg <= 1'b1;
        end else if (overflow_int_ack || overflow_clear) begin
            overflow_reg <= 1'b0;
        end
    end

    // Compare A flag doubles as the top flag in mode 4
    assign counter_value = counter_reg;
    assign compare_a_value = compare_a_reg;
    assign compare_b_value = compare_b_reg;
    assign capture_value = capture_reg;
    assign overflow_flag = overflow_reg;
    assign capture_flag = capture_flag_reg;
    assign compare_a_flag = chan_if[0].flag;
    assign compare_b_flag = chan_if[1].flag;
    assign compare_a_output_bit = chan_if[0].oc_bit;
    assign compare_b_output_bit = chan_if[1].oc_bit;
    assign pin_a_out = chan_if[0].pin_out;
    assign pin_a_oe = chan_if[0].pin_oe;
    assign pin_b_out = chan_if[1].pin_out;
    assign pin_b_oe = chan_if[1].pin_oe;

endmodule : tcoc_timer

// [tcoc_timer_checker.sv]
`timescale 1ns/100ps
module tcoc_timer_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic timer_tick,
    input wire logic [3:0] waveform_mode,
    input wire logic [1:0] compare_a_output_mode,
    input wire logic counter_write,
    input wire logic [15:0] counter_write_value,
    input wire logic force_compare_a_strobe,
    input wire logic overflow_clear,
    input wire logic overflow_int_ack,
    input wire logic port_a_data,
    input wire logic port_a_dir,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] compare_a_value,
    input wire logic overflow_flag,
    input wire logic compare_a_flag,
    input wire logic compare_a_output_bit,
    input wire logic pin_a_out,
    input wire logic pin_a_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic blk_reg;
    logic [3:0] wgm_reg;
    logic hit;
    logic plain;
    // Match blocking after a counter write, and last waveform mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blk_reg <= 1'b0;
            wgm_reg <= 4'h0;
        end else begin
            wgm_reg <= waveform_mode;
            if (counter_write) begin
                blk_reg <= 1'b1;
            end else if (timer_tick) begin
                blk_reg <= 1'b0;
            end
        end
    end
    assign hit = timer_tick && !counter_write && !blk_reg && counter_value == compare_a_value;
    assign plain = waveform_mode == wgm_reg && waveform_mode inside {4'h0, 4'h4, 4'hc};
    property p_wrap;
        timer_tick && !counter_write && counter_value == 16'hffff
            |=> counter_value == 16'h0000 && overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap with overflow");
    property p_sticky;
        overflow_flag && !overflow_clear && !overflow_int_ack |=> overflow_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow lost");
    property p_count;
        waveform_mode == 4'h0 && wgm_reg == 4'h0 && timer_tick && !counter_write
            |=> counter_value == $past(counter_value) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("bad count");
    property p_load;
        counter_write |=> counter_value == $past(counter_write_value);
    endproperty
    a_load: assert property (p_load) else $error("write lost");
    property p_flag;
        hit && plain |=> compare_a_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("no match flag");
    property p_top;
        hit && plain && waveform_mode == 4'h4 |=> counter_value == 16'h0000;
    endproperty
    a_top: assert property (p_top) else $error("no clear at top");
    property p_block;
        timer_tick && blk_reg && !counter_write && !compare_a_flag |=> !compare_a_flag;
    endproperty
    a_block: assert property (p_block) else $error("match not blocked");
    property p_toggle;
        hit && plain && !force_compare_a_strobe && compare_a_output_mode == 2'h1
            && $stable(compare_a_output_mode)
            |=> compare_a_output_bit != $past(compare_a_output_bit);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    property p_action;
        (hit || force_compare_a_strobe) && plain && compare_a_output_mode[1]
            && $stable(compare_a_output_mode)
            |=> compare_a_output_bit == ($past(compare_a_output_mode) == 2'h3);
    endproperty
    a_action: assert property (p_action) else $error("bad set or clear");
    property p_pin;
        1'b1 |=> pin_a_oe == $past(port_a_dir) && pin_a_out == ($past(port_a_dir)
            && ($past(compare_a_output_mode) != 2'h0 ? compare_a_output_bit : $past(port_a_data)));
    endproperty
    a_pin: assert property (p_pin) else $error("bad pin");
    c_top: cover property (hit && waveform_mode == 4'h4);
    c_force: cover property (force_compare_a_strobe);
    c_wrap: cover property (timer_tick && counter_value == 16'hffff);
endmodule : tcoc_timer_checker

bind tcoc_timer tcoc_timer_checker u_checker (.*);

// [tcoc_pin_load.sv]
`timescale 1ns/100ps
module tcoc_pin_load (
    input wire logic clk,
    input wire logic drive,
    input wire logic oe,
    output logic level
);
    logic idle_reg = 1'b0;
    always_ff @(posedge clk) begin
        idle_reg <= ~idle_reg;
    end
    // Undriven pin floats, shown as a changing pattern
    assign level = oe ? drive : idle_reg;
endmodule : tcoc_pin_load

// [tb_tcoc_timer.sv]
`timescale 1ns/100ps
module tb_tcoc_timer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0, cw = 1'b0, aw = 1'b0, pw = 1'b0, frc = 1'b0, clr = 1'b0, ack = 1'b0;
    logic cap = 1'b0;
    logic pdata = 1'b0, pdir = 1'b0, d, exp, oca, ocb, ovf, fa, fb, fcap, pa, pae, pb, pbe, lvl;
    logic [3:0] wgm = 4'h0;
    logic [1:0] com = 2'h0, m;
    logic [15:0] val = 16'h0000, a, cnt, cmpa, cmpb, capv;
    int failures = 0, tests_run = 0, tog;

    tcoc_timer dut (.clk(clk), .rst(rst), .timer_tick(tick), .waveform_mode(wgm),
        .compare_a_output_mode(com), .compare_b_output_mode(com), .counter_write(cw),
        .counter_write_value(val), .compare_a_write(aw), .compare_a_write_value(val),
        .compare_b_write(aw), .compare_b_write_value(val), .capture_write(pw),
        .capture_write_value(val), .capture_event(cap), .force_compare_a_strobe(frc),
        .force_compare_b_strobe(frc), .overflow_clear(clr), .overflow_int_ack(ack),
        .compare_a_clear(clr), .compare_a_int_ack(ack), .compare_b_clear(clr),
        .compare_b_int_ack(ack), .capture_clear(clr), .capture_int_ack(ack),
        .port_a_data(pdata), .port_a_dir(pdir), .port_b_data(pdata), .port_b_dir(pdir),
        .counter_value(cnt), .compare_a_value(cmpa), .compare_b_value(cmpb),
        .capture_value(capv), .overflow_flag(ovf), .compare_a_flag(fa), .compare_b_flag(fb),
        .capture_flag(fcap), .compare_a_output_bit(oca), .compare_b_output_bit(ocb),
        .pin_a_out(pa), .pin_a_oe(pae), .pin_b_out(pb), .pin_b_oe(pbe));
    tcoc_pin_load load (.clk(clk), .drive(pa), .oe(pae), .level(lvl));

    initial begin
        forever #50 clk = ~clk;
    end

    function automatic logic nxt(input logic [1:0] md, input logic b);
        return (md == 2'h0) ? b : (md == 2'h1) ? ~b : md[0];
    endfunction : nxt

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        tests_run++;
        if (got !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    // One-cycle pulse: 0 counter, 1 compare, 2 capture, 3 force, 4 clear, 5 ack, 6 capture event
    task automatic act(input int sel, input logic [15:0] v);
        @(posedge clk);
        val <= v;
        {cap, ack, clr, frc, pw, aw, cw} <= 7'h01 << sel;
        @(posedge clk);
        {cap, ack, clr, frc, pw, aw, cw} <= 7'h00;
        #1;
    endtask : act

    task automatic cfg(input logic [3:0] w, input logic [1:0] c, input logic dir);
        @(posedge clk);
        wgm <= w;
        com <= c;
        pdir <= dir;
        pdata <= 1'($urandom);
        @(posedge clk);
        #1;
    endtask : cfg

    task automatic run(input int n);
        logic prev;
        tog = 0;
        @(posedge clk);
        tick <= 1'b1;
        prev = oca;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == n - 1) tick <= 1'b0;
            #1;
            tog += int'(oca != prev);
            prev = oca;
        end
    endtask : run

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #1000000;
        failures++;
        final_report();
    end

    initial begin
        void'($urandom(69));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("out bit", 16'h0000, oca);
        $display("test reset done");
        act(0, 16'hfffe);
        run(2);
        chk("counter", 16'h0000, cnt);
        chk("overflow", 16'h0001, ovf);
        act(5, 16'h0000);
        chk("overflow", 16'h0000, ovf);
        $display("test wrap done");
        act(1, 16'h0005);
        for (int k = 0; k < 4; k++) begin
            m = 2'(3 - k);
            exp = nxt(m, oca);
            cfg(4'h0, m, 1'b1);
            act(4, 16'h0000);
            act(0, 16'h0004);
            run(2);
            chk("flag a", 16'h0001, fa);
            chk("flag b", 16'h0001, fb);
            chk("out bit", exp, oca);
            chk("out bit b", exp, ocb);
            chk("pin level", m != 2'h0 ? exp : pdata, lvl);
        end
        $display("test match actions done");
        act(4, 16'h0000);
        act(0, 16'h0005);
        repeat (3) @(posedge clk);
        run(1);
        chk("flag a", 16'h0000, fa);
        chk("counter", 16'h0006, cnt);
        $display("test block done");
        for (int k = 1; k < 4; k++) begin
            d = 1'($urandom);
            cfg(4'h0, 2'(k), d);
            exp = nxt(2'(k), oca);
            act(3, 16'h0000);
            chk("out bit", exp, oca);
            chk("flag a", 16'h0000, fa);
            chk("counter", 16'h0006, cnt);
            chk("pin enable", d, pae);
            chk("pin out", d & exp, pa);
            chk("pin b enable", d, pbe);
            chk("pin b out", d & exp, pb);
        end
        cfg(4'h5, 2'h1, 1'b0);
        exp = oca;
        act(3, 16'h0000);
        chk("out bit", exp, oca);
        act(6, 16'h0000);
        chk("capture", 16'h0006, capv);
        chk("capture flag", 16'h0001, fcap);
        $display("test force done");
        a = 16'($urandom_range(4, 1));
        cfg(4'h4, 2'h1, 1'b1);
        act(1, a);
        chk("compare a", a, cmpa);
        chk("compare b", a, cmpb);
        act(4, 16'h0000);
        act(0, 16'h0000);
        run(4 * (int'(a) + 1));
        chk("toggles", 16'h0004, 16'(tog));
        chk("counter", 16'h0000, cnt);
        chk("flag a", 16'h0001, fa);
        $display("test toggle done");
        act(4, 16'h0000);
        act(0, 16'hfff0);
        run(16);
        chk("counter", 16'h0000, cnt);
        chk("overflow", 16'h0001, ovf);
        chk("flag a", 16'h0000, fa);
        run(int'(a) + 1);
        chk("flag a", 16'h0001, fa);
        $display("test low top done");
        act(4, 16'h0000);
        cfg(4'hc, 2'h0, 1'b0);
        act(2, 16'h0003);
        act(0, 16'h0000);
        run(4);
        chk("counter", 16'h0000, cnt);
        chk("capture flag", 16'h0001, fcap);
        $display("test capture top done");
        cfg(4'h0, 2'h3, 1'b1);
        act(3, 16'h0000);
        chk("out bit", 16'h0001, oca);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("out bit", 16'h0000, oca);
        chk("pin enable", 16'h0000, pae);
        $display("test second reset done");
        final_report();
    end
endmodule : tb_tcoc_timer
